// File: src/pwm_phase_pkg.sv
// Shared constants and types of the multiphase PWM phase manager
package pwm_phase_pkg;
  localparam int PER_W = 12;
  localparam int CUR_W = 12;
  localparam int DAT_W = 16;
  localparam int ADR_W = 4;
  localparam int NPH = 4;
  localparam logic [3:0] REG_CFG = 4'h0;
  localparam logic [3:0] REG_PER1 = 4'h1;
  localparam logic [3:0] REG_PER2 = 4'h2;
  localparam logic [3:0] REG_DUTY1 = 4'h3;
  localparam logic [3:0] REG_DUTY2 = 4'h4;
  localparam logic [3:0] REG_GAIN = 4'h5;
  localparam logic [3:0] REG_TOFS = 4'h6;
  localparam logic [3:0] REG_VID = 4'h7;
  localparam logic [3:0] REG_OCP = 4'h8;
  localparam logic [3:0] REG_STAT = 4'h9;
  localparam logic [3:0] REG_TOT1 = 4'hA;
  localparam logic [3:0] REG_TOT2 = 4'hB;
  localparam logic [3:0] REG_AVP = 4'hC;
  localparam logic [3:0] REG_ERR1 = 4'hD;
  localparam logic [3:0] REG_ERR2 = 4'hE;
  localparam int CFG_L1_LSB = 0;
  localparam int CFG_L2_BIT = 2;
  localparam int CFG_MODE_LSB = 3;
  localparam int CFG_DET_BIT = 5;
  localparam int CFG_SKIP_BIT = 6;
  localparam int STAT_OCP1 = 11;
  localparam int STAT_OCP2 = 12;
  localparam logic [1:0] MODE_ATL = 2'h0;
  localparam logic [1:0] MODE_1V8 = 2'h1;
  localparam logic [1:0] MODE_3V3 = 2'h2;
  localparam logic [15:0] CFG_RST = 16'h0067;
  localparam logic [11:0] PER_RST = 12'h0FA;
  localparam logic [11:0] OCP_RST = 12'hFFF;
  localparam int CLK_NS = 20;
  localparam int DET_TIME_NS = 10000;
  localparam int DET_CYC = (DET_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int VID_BASE_MV = 500;
  localparam int VID_STEP_MV = 10;
  localparam logic [7:0] VID_MAX = 8'hB5;
  localparam int FILT_SH = 4;
  localparam int BAL_SH = 2;
  localparam int GAIN_SH = 5;
  localparam int AVP_SH = 3;
  localparam int SKIP_TH = 32;
  typedef enum logic [2:0] {ST_IDLE, ST_DETECT, ST_ARMED, ST_RUN, ST_SHUT} state_type;
endpackage

// File: src/pwm_slot_if.sv
// Slot timing carrier between the phase manager and one pulse slot
`timescale 1ns/1ps
interface pwm_slot_if;
  logic [pwm_phase_pkg::PER_W-1:0] cnt, period, start, width;
  logic pulse;
  modport mgr(output cnt, period, start, width, input pulse);
  modport slot(input cnt, period, start, width, output pulse);
endinterface

// File: src/pwm_phase_slot.sv
// One phase pulse slot: high while the shared count is within width after start
`timescale 1ns/1ps
module pwm_phase_slot (
  pwm_slot_if.slot s
);
  logic [pwm_phase_pkg::PER_W:0] rel;

  always_comb begin
    if (s.cnt >= s.start) begin
      rel = {1'b0, s.cnt - s.start};
    end else begin
      rel = {1'b0, s.cnt} + {1'b0, s.period} - {1'b0, s.start};
    end
  end

  // Pulse begins at its slot boundary and wraps over the period end
  assign s.pulse = rel < {1'b0, s.width};
endmodule

// File: src/pin_sync3.sv
// Three-flop input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } sync_type;
  sync_type r_ff;
  sync_type nxt_r;

  always_comb begin
    nxt_r = r_ff;
    nxt_r.s1 = din;
    nxt_r.s2 = r_ff.s1;
    nxt_r.s3 = r_ff.s2;
    nxt_r.q = (~(r_ff.s2 ^ r_ff.s3) & r_ff.s3) | ((r_ff.s2 ^ r_ff.s3) & r_ff.q);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_ff <= '0;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign dout = r_ff.q;
endmodule

// File: src/multiphase_pwm_phase_manager.sv
// Multiphase PWM phase manager: phasing, detection, driver levels and current processing
//
// Notes on behaviour
// - Loop setups 3+0, 2+0, 1+0, 3+1, 2+1 and 1+1 are supported.
// - Loop one phases interleave evenly: 180 degrees for two, 120 for three.
// - Fewer phases drop the highest-numbered ones first.
// - At start-up a PWM pin below detect threshold marks its phase unpopulated.
// - Active phases shrink to populated ones, never above the stored maximum.
// - Each loop's switching period comes from its own register.
// - Stored driver mode picks tri-level, 1.8V or 3.3V tri-state drive.
// - In 3.3V tri-state mode the middle level is a released pin.
// - Outputs sit at middle level when disabled, after shutdown, before soft-start.
// - Each loop digitises target minus sensed voltage as an error word.
// - Phase currents sum into a total; it feeds monitoring and overcurrent trip.
// - Total current lowers the voltage code reference into the positioning target.
// - Muxed phase currents are filtered and steer duties toward equal share.
// - In transients the widest pulse is skipped when it outruns the narrowest.
// - A per-phase gain offset shifts a phase's share of current.
// - A stored total-current offset is taken off the total reading.
// - Code 0 is off, 1 is 0.50 V, plus 10 mV a step up to B5.
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module multiphase_pwm_phase_manager (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [pwm_phase_pkg::NPH-1:0] detAbove,
  input wire logic softStart,
  input wire logic shutDone,
  input wire logic transient,
  input wire logic [pwm_phase_pkg::CUR_W-1:0] adcData,
  input wire logic adcValid,
  output logic [1:0] muxSel,
  input wire logic [pwm_phase_pkg::PER_W-1:0] vsense1,
  input wire logic [pwm_phase_pkg::PER_W-1:0] vsense2,
  input wire logic [pwm_phase_pkg::ADR_W-1:0] regAddr,
  input wire logic [pwm_phase_pkg::DAT_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [pwm_phase_pkg::DAT_W-1:0] regRdata,
  output logic [pwm_phase_pkg::NPH-1:0] pwmOut,
  output logic [pwm_phase_pkg::NPH-1:0] pwmOeN,
  output logic [pwm_phase_pkg::NPH-1:0] pwmMid,
  output logic pwm33Sel,
  output logic ocpTrip1,
  output logic ocpTrip2
);
  localparam int PW = pwm_phase_pkg::PER_W;

  typedef struct packed {
    pwm_phase_pkg::state_type st;
    logic [15:0] cfg;
    logic [PW-1:0] per1;
    logic [PW-1:0] per2;
    logic [PW-1:0] duty1;
    logic [PW-1:0] duty2;
    logic [15:0] gain;
    logic [PW-1:0] tofs;
    logic [7:0] voltage_id_code;
    logic [PW-1:0] ocpLim;
    logic [PW-1:0] cnt1;
    logic [PW-1:0] cnt2;
    logic [9:0] tmr;
    logic [3:0] det;
    logic [1:0] act1;
    logic act2;
    logic [1:0] mux;
    logic [3:0][15:0] filt;
    logic [13:0] tot1;
    logic [PW-1:0] tot2;
    logic [PW-1:0] adaptive_voltage_positioning;
    logic [12:0] err1;
    logic [12:0] err2;
    logic [3:0] skip;
    logic ocp1;
    logic ocp2;
    logic [3:0] pOut;
    logic [3:0] pOeN;
    logic [3:0] pMid;
    logic p33;
    logic [15:0] rdata;
  } mgr_type;

  mgr_type r_ff;
  mgr_type nxt_r;
  logic [4:0] syncQ;
  logic enQ;
  logic [3:0] detQ;
  logic [1:0] l1Max;
  logic [1:0] detN;
  logic detEn;
  logic [1:0] mode;
  logic vidBad;
  logic [PW-1:0] vidMv;
  logic [PW-1:0] slot;
  logic [2:0][PW-1:0] wid;
  logic [3:0] pulse;
  logic [15:0] status;
  logic inTri;

  pin_sync3 #(.W(5)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .din({enable, detAbove}),
    .dout(syncQ)
  );
  assign enQ = syncQ[4];
  assign detQ = syncQ[3:0];

  // Configured loop one size; a zero field counts as one phase
  assign l1Max = (r_ff.cfg[pwm_phase_pkg::CFG_L1_LSB +: 2] == 2'h0) ? 2'h1 :
    r_ff.cfg[pwm_phase_pkg::CFG_L1_LSB +: 2];
  // Populated phases count upward from phase one until the first missing pin
  assign detN = !detQ[0] ? 2'h0 : !detQ[1] ? 2'h1 : !detQ[2] ? 2'h2 : 2'h3;
  assign detEn = r_ff.cfg[pwm_phase_pkg::CFG_DET_BIT];
  assign mode = r_ff.cfg[pwm_phase_pkg::CFG_MODE_LSB +: 2];
  assign vidBad = r_ff.voltage_id_code > pwm_phase_pkg::VID_MAX;
  assign vidMv = (r_ff.voltage_id_code == 8'h00 || vidBad) ? '0 : PW'(pwm_phase_pkg::VID_BASE_MV +
    pwm_phase_pkg::VID_STEP_MV * (int'(r_ff.voltage_id_code) - 1));
  // Equal slot per active loop one phase
  assign slot = (r_ff.act1 == 2'h3) ? PW'(r_ff.per1 / 3) :
    (r_ff.act1 == 2'h2) ? (r_ff.per1 >> 1) : '0;
  assign status = {3'h0, r_ff.ocp2, r_ff.ocp1, vidBad, r_ff.act2, r_ff.act1, r_ff.det, r_ff.st};
  assign inTri = r_ff.st == pwm_phase_pkg::ST_IDLE || r_ff.st == pwm_phase_pkg::ST_DETECT ||
    r_ff.st == pwm_phase_pkg::ST_ARMED;

  pwm_slot_if sl [4] ();
  for (genvar g = 0; g < 4; g++) begin : g_slot
    assign sl[g].cnt = (g < 3) ? r_ff.cnt1 : r_ff.cnt2;
    assign sl[g].period = (g < 3) ? r_ff.per1 : r_ff.per2;
    assign sl[g].start = (g < 3) ? PW'(g * int'(slot)) : '0;
    assign sl[g].width = (g < 3) ? wid[g] : r_ff.duty2;
    assign pulse[g] = sl[g].pulse;
    pwm_phase_slot u_slot (
      .s(sl[g].slot)
    );
  end

  always_comb begin
    int n;
    int sum;
    int tadj;
    int avg;
    int wmax;
    int wmin;
    int imax;
    int c;
    int t;
    int cadj [3];
    logic on;
    n = int'(r_ff.act1);
    sum = 0;
    tadj = 0;
    avg = 0;
    wmax = 0;
    wmin = 0;
    imax = 0;
    c = 0;
    t = 0;
    cadj = '{0, 0, 0};
    on = 1'b0;
    nxt_r = r_ff;
    wid = '0;
    // Register writes; status write clears trip flags
    if (regWr) begin
      case (regAddr)
        pwm_phase_pkg::REG_CFG: nxt_r.cfg = regWdata;
        pwm_phase_pkg::REG_PER1: nxt_r.per1 = regWdata[PW-1:0];
        pwm_phase_pkg::REG_PER2: nxt_r.per2 = regWdata[PW-1:0];
        pwm_phase_pkg::REG_DUTY1: nxt_r.duty1 = regWdata[PW-1:0];
        pwm_phase_pkg::REG_DUTY2: nxt_r.duty2 = regWdata[PW-1:0];
        pwm_phase_pkg::REG_GAIN: nxt_r.gain = regWdata;
        pwm_phase_pkg::REG_TOFS: nxt_r.tofs = regWdata[PW-1:0];
        pwm_phase_pkg::REG_VID: nxt_r.voltage_id_code = regWdata[7:0];
        pwm_phase_pkg::REG_OCP: nxt_r.ocpLim = regWdata[PW-1:0];
        pwm_phase_pkg::REG_STAT: begin
          nxt_r.ocp1 = r_ff.ocp1 & ~regWdata[pwm_phase_pkg::STAT_OCP1];
          nxt_r.ocp2 = r_ff.ocp2 & ~regWdata[pwm_phase_pkg::STAT_OCP2];
        end
        default: begin
        end
      endcase
    end
    nxt_r.rdata = '0;
    if (regRd) begin
      case (regAddr)
        pwm_phase_pkg::REG_CFG: nxt_r.rdata = r_ff.cfg;
        pwm_phase_pkg::REG_PER1: nxt_r.rdata = 16'(r_ff.per1);
        pwm_phase_pkg::REG_PER2: nxt_r.rdata = 16'(r_ff.per2);
        pwm_phase_pkg::REG_DUTY1: nxt_r.rdata = 16'(r_ff.duty1);
        pwm_phase_pkg::REG_DUTY2: nxt_r.rdata = 16'(r_ff.duty2);
        pwm_phase_pkg::REG_GAIN: nxt_r.rdata = r_ff.gain;
        pwm_phase_pkg::REG_TOFS: nxt_r.rdata = 16'(r_ff.tofs);
        pwm_phase_pkg::REG_VID: nxt_r.rdata = 16'(r_ff.voltage_id_code);
        pwm_phase_pkg::REG_OCP: nxt_r.rdata = 16'(r_ff.ocpLim);
        pwm_phase_pkg::REG_STAT: nxt_r.rdata = status;
        pwm_phase_pkg::REG_TOT1: nxt_r.rdata = 16'(r_ff.tot1);
        pwm_phase_pkg::REG_TOT2: nxt_r.rdata = 16'(r_ff.tot2);
        pwm_phase_pkg::REG_AVP: nxt_r.rdata = 16'(r_ff.adaptive_voltage_positioning);
        pwm_phase_pkg::REG_ERR1: nxt_r.rdata = 16'($signed(r_ff.err1));
        pwm_phase_pkg::REG_ERR2: nxt_r.rdata = 16'($signed(r_ff.err2));
        default: nxt_r.rdata = '0;
      endcase
    end
    // Per-loop period counters
    nxt_r.cnt1 = (r_ff.cnt1 >= r_ff.per1 - PW'(1)) ? '0 : r_ff.cnt1 + PW'(1);
    nxt_r.cnt2 = (r_ff.cnt2 >= r_ff.per2 - PW'(1)) ? '0 : r_ff.cnt2 + PW'(1);
    case (r_ff.st)
      pwm_phase_pkg::ST_IDLE: begin
        nxt_r.tmr = '0;
        if (enQ) begin
          nxt_r.st = pwm_phase_pkg::ST_DETECT;
        end
      end
      pwm_phase_pkg::ST_DETECT: begin
        nxt_r.tmr = r_ff.tmr + 10'h001;
        if (r_ff.tmr == 10'(pwm_phase_pkg::DET_CYC - 1)) begin
          nxt_r.det = detQ;
          nxt_r.act1 = (detEn && detN < l1Max) ? detN : l1Max;
          nxt_r.act2 = r_ff.cfg[pwm_phase_pkg::CFG_L2_BIT] && (!detEn || detQ[3]);
          nxt_r.st = enQ ? pwm_phase_pkg::ST_ARMED : pwm_phase_pkg::ST_IDLE;
        end
      end
      pwm_phase_pkg::ST_ARMED: begin
        if (!enQ) begin
          nxt_r.st = pwm_phase_pkg::ST_IDLE;
        end else if (softStart) begin
          nxt_r.st = pwm_phase_pkg::ST_RUN;
        end
      end
      pwm_phase_pkg::ST_RUN: begin
        if (!enQ) begin
          nxt_r.st = pwm_phase_pkg::ST_SHUT;
        end
      end
      pwm_phase_pkg::ST_SHUT: begin
        if (shutDone) begin
          nxt_r.st = pwm_phase_pkg::ST_IDLE;
        end
      end
      default: nxt_r.st = pwm_phase_pkg::ST_IDLE;
    endcase
    // Monitor ADC sample of the muxed phase, first-order low-pass
    if (adcValid) begin
      t = int'({adcData, 4'h0}) - int'(r_ff.filt[r_ff.mux]);
      nxt_r.filt[r_ff.mux] = 16'(int'(r_ff.filt[r_ff.mux]) + (t >>> pwm_phase_pkg::FILT_SH));
      nxt_r.mux = r_ff.mux + 2'h1;
    end
    for (int k = 0; k < 3; k++) begin
      c = int'(r_ff.filt[k][15:4]);
      cadj[k] = c - ((c * int'($signed(r_ff.gain[4*k +: 4]))) >>> pwm_phase_pkg::GAIN_SH);
      if (k < n) begin
        sum = sum + c;
        tadj = tadj + cadj[k];
      end
    end
    avg = (n == 0) ? 0 : tadj / n;
    for (int k = 0; k < 3; k++) begin
      t = int'(r_ff.duty1) + ((avg - cadj[k]) >>> pwm_phase_pkg::BAL_SH);
      if (t < 0) begin
        t = 0;
      end else if (t > int'(r_ff.per1)) begin
        t = int'(r_ff.per1);
      end
      wid[k] = PW'(t);
      if (k < n && t > wmax) begin
        wmax = t;
        imax = k;
      end
      if (k < n && (k == 0 || t < wmin)) begin
        wmin = t;
      end
    end
    // Skip decision is taken once per loop one period
    if (r_ff.cnt1 == '0) begin
      nxt_r.skip = '0;
      if (transient && r_ff.cfg[pwm_phase_pkg::CFG_SKIP_BIT] && n > 1 &&
          wmax - wmin > pwm_phase_pkg::SKIP_TH) begin
        nxt_r.skip[imax] = 1'b1;
      end
    end
    t = sum - int'(r_ff.tofs);
    nxt_r.tot1 = (t < 0) ? '0 : 14'(t);
    t = r_ff.act2 ? int'(r_ff.filt[3][15:4]) - int'(r_ff.tofs) : 0;
    nxt_r.tot2 = (t < 0) ? '0 : PW'(t);
    // Trip flags set after the clear so a new trip wins
    if (r_ff.tot1 > {2'b00, r_ff.ocpLim}) begin
      nxt_r.ocp1 = 1'b1;
    end
    if (r_ff.tot2 > r_ff.ocpLim) begin
      nxt_r.ocp2 = 1'b1;
    end
    t = int'(vidMv) - (int'(r_ff.tot1) >>> pwm_phase_pkg::AVP_SH);
    nxt_r.adaptive_voltage_positioning = (t < 0 || vidMv == '0) ? '0 : PW'(t);
    nxt_r.err1 = 13'(int'(r_ff.adaptive_voltage_positioning) - int'(vsense1));
    nxt_r.err2 = 13'(int'(vidMv) - int'(vsense2));
    // Pin levels: high, low or the mode's middle level
    for (int k = 0; k < 4; k++) begin
      on = (r_ff.st == pwm_phase_pkg::ST_RUN || r_ff.st == pwm_phase_pkg::ST_SHUT) &&
        ((k < 3) ? (k < n) : r_ff.act2);
      if (on) begin
        nxt_r.pOut[k] = pulse[k] && !r_ff.skip[k];
        nxt_r.pOeN[k] = 1'b0;
        nxt_r.pMid[k] = 1'b0;
      end else if (mode == pwm_phase_pkg::MODE_3V3) begin
        nxt_r.pOut[k] = 1'b0;
        nxt_r.pOeN[k] = 1'b1;
        nxt_r.pMid[k] = 1'b0;
      end else begin
        nxt_r.pOut[k] = 1'b0;
        nxt_r.pOeN[k] = 1'b0;
        nxt_r.pMid[k] = 1'b1;
      end
    end
    nxt_r.p33 = mode == pwm_phase_pkg::MODE_3V3;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_ff <= '0;
      r_ff.cfg <= pwm_phase_pkg::CFG_RST;
      r_ff.per1 <= pwm_phase_pkg::PER_RST;
      r_ff.per2 <= pwm_phase_pkg::PER_RST;
      r_ff.ocpLim <= pwm_phase_pkg::OCP_RST;
      r_ff.pMid <= 4'hF;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign muxSel = r_ff.mux;
  assign regRdata = r_ff.rdata;
  assign pwmOut = r_ff.pOut;
  assign pwmOeN = r_ff.pOeN;
  assign pwmMid = r_ff.pMid;
  assign pwm33Sel = r_ff.p33;
  assign ocpTrip1 = r_ff.ocp1;
  assign ocpTrip2 = r_ff.ocp2;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence triHeld;
    inTri ##1 inTri;
  endsequence
  sequence twoPhaseRun;
    r_ff.st == pwm_phase_pkg::ST_RUN && r_ff.act1 == 2'h2;
  endsequence

  idle_mid_level_a: assert property (triHeld |-> &(pwmOeN | pwmMid))
    else $error("PWM pin driven while outputs should be at middle level");
  float_3v3_a: assert property (triHeld ##0 pwm33Sel |-> pwmOeN == 4'hF && pwmMid == 4'h0 &&
    pwmOut == 4'h0)
    else $error("Middle level not released in 3.3V mode");
  drop_high_a: assert property (twoPhaseRun ##1 twoPhaseRun |-> !pwmOut[2])
    else $error("Dropped phase three still pulses");
  cfg_cap_a: assert property (r_ff.st == pwm_phase_pkg::ST_ARMED |-> r_ff.act1 <= l1Max)
    else $error("Active phases exceed configured maximum");
  det_missing_a: assert property (r_ff.st == pwm_phase_pkg::ST_ARMED && detEn &&
    !r_ff.det[0] |-> r_ff.act1 == 2'h0)
    else $error("Unpopulated phase one left active");
  period_wrap_a: assert property (r_ff.per1 > 12'h001 && r_ff.cnt1 == r_ff.per1 - 12'h001 &&
    !regWr |=> r_ff.cnt1 == 12'h000)
    else $error("Loop one counter did not wrap at its period");
  vid_decode_a: assert property ((r_ff.voltage_id_code == 8'h01 |-> vidMv == 12'h1F4) and
    (r_ff.voltage_id_code == pwm_phase_pkg::VID_MAX |-> vidMv == 12'h8FC))
    else $error("Voltage code decode is wrong");
  half_space_a: assert property (r_ff.act1 == 2'h2 |-> sl[1].start == r_ff.per1 >> 1)
    else $error("Two-phase start offset is not half a period");
  skip_cause_a: assert property (r_ff.cnt1 == 12'h000 && !transient |=> r_ff.skip == 4'h0)
    else $error("Pulse skip set outside a transient");
  ocp_set_a: assert property (r_ff.tot1 > {2'b00, r_ff.ocpLim} |=> ocpTrip1)
    else $error("Overcurrent flag not raised");
endmodule

// File: test/pwm_driver_model.sv
// Driver-side model: pin levels seen by the drivers and the start-up detect comparators
`timescale 1ns/1ps
module pwm_driver_model (
  input wire logic [3:0] pwmOut,
  input wire logic [3:0] pwmOeN,
  input wire logic [3:0] pwmMid,
  input wire logic pwm33Sel,
  input wire logic [3:0] popMask,
  output logic [3:0] detAbove,
  output logic [3:0] pinHigh,
  output logic [3:0] pinMid
);
  // Fitted phases sit above threshold; unfitted ones are grounded, each as popMask sets it
  assign detAbove = popMask;
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      // A released pin reaches mid only through the 3.3V divider
      pinMid[k] = pwmOeN[k] ? pwm33Sel : pwmMid[k];
      pinHigh[k] = pwmOeN[k] ? 1'b0 : (!pwmMid[k] && pwmOut[k]);
    end
  end
endmodule

// File: test/multiphase_pwm_phase_manager_tb_top.sv
// Self-checking bench for the multiphase PWM phase manager
`timescale 1ns/1ps
module multiphase_pwm_phase_manager_tb_top;
  typedef struct packed {
    logic [3:0] addr;
    logic wr;
    logic [15:0] wdata;
    logic [15:0] expRd;
    logic exp33;
  } row_type;
  logic clk, pwm33Sel, ocpTrip1, ocpTrip2;
  logic rst_n = 1'b0;
  logic enable = 1'b0;
  logic softStart = 1'b0;
  logic shutDone = 1'b0;
  logic transient = 1'b0;
  logic adcValid = 1'b0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [3:0] popMask = 4'hB;
  logic [3:0] detAbove, pwmOut, pwmOeN, pwmMid, pinHigh, pinMid;
  logic [1:0] muxSel;
  logic [11:0] adcData = 12'h400;
  logic [11:0] vsense1 = 12'h384;
  logic [11:0] vsense2 = 12'h3F2;
  logic [15:0] regWdata = 16'h0000;
  logic [15:0] regRdata, rdVal;
  int errTotal = 0;
  int comparisons = 0;
  int cyc = 0;
  int t0, t1, t2;
  logic [7:0] vidCode [3] = '{8'hB5, 8'hB6, 8'h00};
  logic [15:0] vidMv [3] = '{16'h08FC, 16'h0000, 16'h0000};
  row_type rows [17] = '{
    '{4'h0, 1'b0, 16'h0000, 16'h0067, 1'b0},
    '{4'h1, 1'b0, 16'h0000, 16'h00FA, 1'b0},
    '{4'h2, 1'b0, 16'h0000, 16'h00FA, 1'b0},
    '{4'h8, 1'b0, 16'h0000, 16'h0FFF, 1'b0},
    '{4'h9, 1'b0, 16'h0000, 16'h0000, 1'b0},
    '{4'h0, 1'b1, 16'h0077, 16'h0077, 1'b1},
    '{4'h0, 1'b1, 16'h006F, 16'h006F, 1'b0},
    '{4'h0, 1'b1, 16'h0067, 16'h0067, 1'b0},
    '{4'h1, 1'b1, 16'h0064, 16'h0064, 1'b0},
    '{4'h2, 1'b1, 16'h00C8, 16'h00C8, 1'b0},
    '{4'h3, 1'b1, 16'h0014, 16'h0014, 1'b0},
    '{4'h4, 1'b1, 16'h0014, 16'h0014, 1'b0},
    '{4'h5, 1'b1, 16'h0000, 16'h0000, 1'b0},
    '{4'h6, 1'b1, 16'h0000, 16'h0000, 1'b0},
    '{4'h7, 1'b1, 16'h0033, 16'h0033, 1'b0},
    '{4'hF, 1'b1, 16'h1234, 16'h0000, 1'b0},
    '{4'hA, 1'b1, 16'h1234, 16'h0000, 1'b0}
  };

  multiphase_pwm_phase_manager i_dut (
    .clk(clk), .rst_n(rst_n), .enable(enable), .detAbove(detAbove),
    .softStart(softStart), .shutDone(shutDone), .transient(transient),
    .adcData(adcData), .adcValid(adcValid), .muxSel(muxSel),
    .vsense1(vsense1), .vsense2(vsense2), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pwmOut(pwmOut),
    .pwmOeN(pwmOeN), .pwmMid(pwmMid), .pwm33Sel(pwm33Sel),
    .ocpTrip1(ocpTrip1), .ocpTrip2(ocpTrip2)
  );

  pwm_driver_model i_drv (
    .pwmOut(pwmOut), .pwmOeN(pwmOeN), .pwmMid(pwmMid), .pwm33Sel(pwm33Sel),
    .popMask(popMask), .detAbove(detAbove), .pinHigh(pinHigh), .pinMid(pinMid)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic endOfTest();
    $display("comparisons %0d mismatches %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errTotal++;
      $display("BAD timeout expected finish seen hang");
      endOfTest();
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errTotal++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    d = regRdata;
  endtask

  task automatic pollState(input logic [2:0] s);
    int n;
    n = 0;
    rd(4'h9, rdVal);
    while (rdVal[2:0] !== s && n < 400) begin
      rd(4'h9, rdVal);
      n++;
    end
  endtask

  task automatic riseAt(input int k, output int t);
    int n;
    n = 0;
    while (pinHigh[k] !== 1'b0 && n < 1000) begin
      @(posedge clk);
      #1;
      n++;
    end
    while (pinHigh[k] !== 1'b1 && n < 1000) begin
      @(posedge clk);
      #1;
      n++;
    end
    t = cyc;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    chk("rdIdle", regRdata, 16'h0000);
    chk("muxRst", {14'h0, muxSel}, 16'h0000);
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wr(rows[i].addr, rows[i].wdata);
      end
      rd(rows[i].addr, rdVal);
      chk("regRead", rdVal, rows[i].expRd);
      chk("sel33", {15'h0, pwm33Sel}, {15'h0, rows[i].exp33});
      chk("oeN", {12'h0, pwmOeN}, rows[i].exp33 ? 16'h000F : 16'h0000);
      chk("pinMid", {12'h0, pinMid}, 16'h000F);
    end
    $display("test registers done");
    @(posedge clk);
    enable <= 1'b1;
    pollState(3'h2);
    chk("statDet", rdVal, 16'h035A);
    chk("midArmed", {12'h0, pinMid}, 16'h000F);
    $display("test detect done");
    @(posedge clk);
    softStart <= 1'b1;
    riseAt(0, t0);
    @(posedge clk);
    softStart <= 1'b0;
    riseAt(1, t1);
    chk("lag12", 16'(t1 - t0), 16'h0032);
    riseAt(0, t2);
    chk("per1", 16'(t2 - t0), 16'h0064);
    chk("ph3Off", {15'h0, pwmMid[2]}, 16'h0001);
    riseAt(3, t0);
    riseAt(3, t1);
    chk("per2", 16'(t1 - t0), 16'h00C8);
    $display("test phasing done");
    rd(4'hC, rdVal);
    chk("avp", rdVal, 16'h03E8);
    rd(4'hD, rdVal);
    chk("err1", rdVal, 16'h0064);
    rd(4'hE, rdVal);
    chk("err2", rdVal, 16'hFFF6);
    for (int i = 0; i < 3; i++) begin
      wr(4'h7, {8'h00, vidCode[i]});
      rd(4'hC, rdVal);
      chk("avpVid", rdVal, vidMv[i]);
      rd(4'h9, rdVal);
      chk("vidBad", {15'h0, rdVal[10]}, (i == 1) ? 16'h0001 : 16'h0000);
    end
    $display("test voltage code done");
    wr(4'h8, 16'h0010);
    for (int i = 0; i < 201; i++) begin
      @(posedge clk);
      adcValid <= 1'b1;
      @(posedge clk);
      adcValid <= 1'b0;
    end
    @(posedge clk);
    #1;
    chk("muxSel", {14'h0, muxSel}, 16'h0001);
    chk("ocp1", {15'h0, ocpTrip1}, 16'h0001);
    chk("ocp2", {15'h0, ocpTrip2}, 16'h0001);
    $display("test current done");
    rd(4'hA, rdVal);
    t0 = int'(rdVal);
    wr(4'h6, 16'h0010);
    rd(4'hA, rdVal);
    chk("totOfs", rdVal, 16'(t0 - 16));
    wr(4'h7, 16'h0033);
    rd(4'hC, rdVal);
    chk("avpLoad", rdVal, 16'(1000 - (t0 - 16) / 8));
    wr(4'h9, 16'h1800);
    rd(4'h9, rdVal);
    chk("ocpHold", {14'h0, rdVal[12:11]}, 16'h0003);
    wr(4'h8, 16'h0FFF);
    wr(4'h9, 16'h1800);
    rd(4'h9, rdVal);
    chk("ocpClr", {14'h0, rdVal[12:11]}, 16'h0000);
    $display("test offsets done");
    wr(4'h5, 16'h0008);
    t0 = 0;
    t1 = 0;
    repeat (200) begin
      @(posedge clk);
      #1;
      t0 += int'(pinHigh[0]);
      t1 += int'(pinHigh[1]);
    end
    chk("gainOff", 16'(t0), 16'h0000);
    chk("balWide", {15'h0, t1 > 60}, 16'h0001);
    @(posedge clk);
    transient <= 1'b1;
    repeat (150) @(posedge clk);
    t1 = 0;
    repeat (200) begin
      @(posedge clk);
      #1;
      t1 += int'(pinHigh[1]);
    end
    chk("skipWide", 16'(t1), 16'h0000);
    @(posedge clk);
    transient <= 1'b0;
    $display("test balance done");
    @(posedge clk);
    enable <= 1'b0;
    pollState(3'h4);
    chk("stShut", {13'h0, rdVal[2:0]}, 16'h0004);
    @(posedge clk);
    shutDone <= 1'b1;
    pollState(3'h0);
    chk("stIdle", {13'h0, rdVal[2:0]}, 16'h0000);
    chk("midOff", {12'h0, pinMid}, 16'h000F);
    @(posedge clk);
    shutDone <= 1'b0;
    $display("test shutdown done");
    wr(4'h0, 16'h0065);
    popMask <= 4'hF;
    enable <= 1'b1;
    pollState(3'h2);
    chk("statMax", rdVal & 16'h07FF, 16'h02FA);
    @(posedge clk);
    enable <= 1'b0;
    pollState(3'h0);
    chk("armAbort", {13'h0, rdVal[2:0]}, 16'h0000);
    wr(4'h0, 16'h0067);
    popMask <= 4'h1;
    enable <= 1'b1;
    pollState(3'h2);
    chk("statOne", rdVal & 16'h07FF, 16'h008A);
    $display("test stored maximum done");
    @(posedge clk);
    rst_n <= 1'b0;
    enable <= 1'b0;
    @(posedge clk);
    #1;
    chk("rstMux", {14'h0, muxSel}, 16'h0000);
    chk("rstMid", {12'h0, pwmMid}, 16'h000F);
    @(posedge clk);
    rst_n <= 1'b1;
    rd(4'h9, rdVal);
    chk("rstStat", rdVal, 16'h0000);
    $display("test reset done");
    endOfTest();
  end
endmodule
